// >>> core/sysclk_ctrl.sv
`timescale 1ns/10ps
`include "sysclk_params.svh"
// What this block does
// - Pick external, crystal, locked loop or loop.
// - Loop mode bit chooses standalone or crystal-locked.
// - Count 65,536 oscillations after each restart from stop on crystal or external; loop sources run at once.
// - Run from loop while warming, then switch.
// - Divide select resets to divide by one.
// - Divide select plus POWER_MANAGEMENT_MODE give five divisors.
// - In POWER_MANAGEMENT_MODE one system clock is 256 cycles.
// - Switchback on external interrupt or serial activity.
// - Stop mode halts oscillator and system clock.
// - Monitor enable bit; ready flag when settled.
// - Threshold selects 2.7V to 3.5V, 0.1V steps.
// - Threshold field resets to 07h.
// - Supply low with enable raises irq, switchback.
// - Keep-in-stop bit keeps monitor on in stop.
// - Active monitor's supply-low irq wakes from stop.
module sysclk_ctrl #(
  parameter int WARMUP_COUNT = `WARMUP_OSC
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                reset,
  // APB slave
  input  wire sysclk_pkg::apbReq_t apbReq,
  output sysclk_pkg::apbRsp_t      apbRsp,
  // Oscillator and supply comparator pins
  input  wire logic                oscIn,
  input  wire logic                supplyLow,
  // Switchback sources
  input  wire logic                extIrq,
  input  wire logic                serialActive,
  // Clock and monitor outputs
  output logic                     sysClkTick,
  output logic                     oscEnable,
  output logic                     fllLocked,
  output logic [1:0]               activeSrc,
  output logic [3:0]               supplyThreshold,
  output logic                     monitorPowered,
  // Interrupt
  output logic                     irq
);
  import sysclk_pkg::*;

  initial begin
    if (WARMUP_COUNT < 1 || WARMUP_COUNT > 131071) begin
      $error("WARMUP_COUNT out of range");
    end
  end

  state_t s_q;
  state_t s_d;
  logic   wr;
  logic   rd;
  logic   oscEdge;
  logic   swEvent;
  logic   lowEvt;
  logic   wakeEvt;
  logic [7:0] divLimit;

  assign wr = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign rd = apbReq.psel && apbReq.penable && !apbReq.pwrite;

  always_comb begin
    s_d = s_q;
    // supplyLow, extIrq and oscIn pass two flops before logic reads them; serialActive is read directly.
    s_d.lowSync1 = supplyLow;
    s_d.lowSync2 = s_q.lowSync1;
    s_d.irqSync1 = extIrq;
    s_d.irqSync2 = s_q.irqSync1;
    s_d.oscSync1 = oscIn;
    s_d.oscSync2 = s_q.oscSync1;
    s_d.oscPrev  = s_q.oscSync2;
    oscEdge = s_q.oscSync2 && !s_q.oscPrev;
    lowEvt  = s_q.svActive && s_q.svRdy && s_q.lowSync2;
    wakeEvt = lowEvt && s_q.svIe;
    swEvent = s_q.swben && (s_q.irqSync2 || serialActive)
              || wakeEvt;

    // Divider: POWER_MANAGEMENT_MODE overrides the divide select with 256.
    case (s_q.cdiv)
      2'h0:    divLimit = 8'h00;
      2'h1:    divLimit = 8'h01;
      2'h2:    divLimit = 8'h03;
      default: divLimit = 8'h07;
    endcase
    if (s_q.power_manage_enable) begin
      divLimit = 8'(`PMM_DIV - 1);
    end

    s_d.sysTick = 1'b0;
    if (s_q.mode != ST_STOP) begin
      if (s_q.divCnt >= divLimit) begin
        s_d.divCnt  = 8'h00;
        s_d.sysTick = 1'b1;
      end else begin
        s_d.divCnt = s_q.divCnt + 8'h01;
      end
    end

    case (s_q.mode)
      ST_RUN: begin
        s_d.mode = ST_RUN;
      end
      ST_STOP: begin
        s_d.divCnt = 8'h00;
        if (wakeEvt || s_q.irqSync2) begin
          s_d.warmCnt = 17'h0;
          if (s_q.src == SRC_XTAL || s_q.src == SRC_EXT) begin
            s_d.mode = ST_WARM;
          end else begin
            s_d.mode = ST_RUN;
          end
        end
      end
      ST_WARM: begin
        if (oscEdge) begin
          if (s_q.warmCnt == 17'(WARMUP_COUNT - 1)) begin
            s_d.mode = ST_RUN;
          end else begin
            s_d.warmCnt = s_q.warmCnt + 17'h1;
          end
        end
      end
      default: begin
        s_d.mode = ST_RUN;
      end
    endcase

    // Monitor settling and ready flag.
    if (!s_q.svActive) begin
      s_d.settleCnt = 16'h0;
      s_d.svRdy     = 1'b0;
    end else if (!s_q.svRdy) begin
      if (s_q.settleCnt == 16'(`SVM_SETTLE_CYC - 1)) begin
        s_d.svRdy = 1'b1;
      end else begin
        s_d.settleCnt = s_q.settleCnt + 16'h1;
      end
    end

    // Register writes; read data holds until the next read.
    if (wr) begin
      case (apbReq.paddr)
        `CKCTRL_OFS: begin
          s_d.cdiv  = apbReq.pwdata[`CK_CDIV_LSB +: 2];
          s_d.power_manage_enable  = apbReq.pwdata[`CK_POWER_MANAGE_ENABLE_BIT];
          s_d.loop_mode_select = apbReq.pwdata[`CK_LOOP_MODE_SELECT_BIT];
          s_d.swben = apbReq.pwdata[`CK_SWBEN_BIT];
          s_d.src   = clkSrc_t'(apbReq.pwdata[`CK_SRC_LSB +: 2]);
          if (s_d.src == SRC_FLLX || s_d.src == SRC_FLL) begin
            s_d.src = s_d.loop_mode_select ? SRC_FLLX : SRC_FLL;
          end
        end
        `SVCTRL_OFS: begin
          s_d.svEn   = apbReq.pwdata[`SV_EN_BIT];
          s_d.svIe   = apbReq.pwdata[`SV_IE_BIT];
          s_d.svStop = apbReq.pwdata[`SV_STOP_BIT];
          s_d.supply_threshold_field   = apbReq.pwdata[`SV_TH_LSB +: 4];
        end
        `IMASK_OFS: begin
          s_d.mask = apbReq.pwdata[2:0];
        end
        `STOPCMD_OFS: begin
          if (apbReq.pwdata[0]) begin
            s_d.mode = ST_STOP;
          end
        end
        default: begin
          s_d.mode = s_d.mode;
        end
      endcase
    end

    // An enabled monitor is powered unless stopped without keep-in-stop.
    s_d.svActive = s_d.svEn && (s_d.mode != ST_STOP || s_d.svStop);

    // Next mode decides the loop, so warmup never shows the crystal.
    s_d.useFll = (s_d.src == SRC_FLL) || (s_d.src == SRC_FLLX)
                 || (s_d.mode == ST_WARM);

    // Register reads; status clears on read.
    if (rd) begin
      case (apbReq.paddr)
        `CKCTRL_OFS: begin
          s_d.rdata = {25'h0, s_q.swben, s_q.src, s_q.loop_mode_select,
                       s_q.power_manage_enable, s_q.cdiv};
        end
        `SVCTRL_OFS: begin
          s_d.rdata = {24'h0, s_q.supply_threshold_field, s_q.svRdy, s_q.svStop,
                       s_q.svIe, s_q.svEn};
        end
        `STATUS_OFS: begin
          s_d.rdata = {25'h0, s_q.useFll, s_q.mode, s_q.power_manage_enable, s_q.stat};
          s_d.stat  = 3'h0;
        end
        `IMASK_OFS: begin
          s_d.rdata = {29'h0, s_q.mask};
        end
        default: begin
          s_d.rdata = 32'h0;
        end
      endcase
    end

    // Events set sticky bits; a set wins over the read clear.
    if (lowEvt && s_q.svIe) begin
      s_d.stat[0] = 1'b1;
    end
    if (swEvent && s_q.power_manage_enable) begin
      s_d.stat[1] = 1'b1;
      s_d.power_manage_enable    = 1'b0;
    end
    if (s_q.mode == ST_WARM && s_d.mode == ST_RUN) begin
      s_d.stat[2] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_q       <= '0;
      s_q.mode  <= ST_RUN;
      s_q.src   <= clkSrc_t'(`SRC_RST);
      s_q.cdiv  <= `CDIV_RST;
      s_q.supply_threshold_field  <= `SUPPLY_THRESHOLD_FIELD_RST;
      s_q.loop_mode_select <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero-wait APB writes: the answer rises in the access phase itself.
  // Read data is registered one cycle, so reads take one wait state.
  logic rdPending_q;
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdPending_q <= 1'b0;
    end else begin
      rdPending_q <= rd && !rdPending_q;
    end
  end

  always_comb begin
    apbRsp.pready  = apbReq.psel && apbReq.penable
                     && (apbReq.pwrite || rdPending_q);
    apbRsp.pslverr = 1'b0;
    apbRsp.prdata  = s_q.rdata;
  end

  assign sysClkTick      = s_q.sysTick;
  assign oscEnable       = (s_q.mode != ST_STOP);
  assign fllLocked       = s_q.useFll && s_q.loop_mode_select;
  assign activeSrc       = !s_q.useFll ? 2'(s_q.src) :
                           s_q.loop_mode_select   ? 2'(SRC_FLLX) : 2'(SRC_FLL);
  assign supplyThreshold = s_q.supply_threshold_field;
  assign monitorPowered  = s_q.svActive;
  assign irq             = |(s_q.stat & s_q.mask);
endmodule

// >>> core/sysclk_params.svh
`ifndef SYSCLK_PARAMS_SVH
`define SYSCLK_PARAMS_SVH
// Register byte offsets on the APB bus.
`define CKCTRL_OFS     12'h000
`define SVCTRL_OFS     12'h004
`define STATUS_OFS     12'h008
`define IMASK_OFS      12'h00C
`define STOPCMD_OFS    12'h010
// Clock control field positions.
`define CK_CDIV_LSB    0
`define CK_POWER_MANAGE_ENABLE_BIT    2
`define CK_LOOP_MODE_SELECT_BIT   3
`define CK_SRC_LSB     4
`define CK_SWBEN_BIT   6
// Supply control field positions.
`define SV_EN_BIT      0
`define SV_IE_BIT      1
`define SV_STOP_BIT    2
`define SV_TH_LSB      4
// Reset values.
`define CDIV_RST       2'h0
`define SUPPLY_THRESHOLD_FIELD_RST       4'h7
`define SRC_RST        2'h2
// Timing counts.
`define WARMUP_OSC     65536
`define PMM_DIV        256
`define SVM_SETTLE_NS  1000
`define CLK_NS         10
`define SVM_SETTLE_CYC ((`SVM_SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// >>> core/sysclk_pkg.sv
package sysclk_pkg;
  typedef enum logic [1:0] {
    SRC_EXT  = 2'h0,
    SRC_XTAL = 2'h1,
    SRC_FLLX = 2'h2,
    SRC_FLL  = 2'h3
  } clkSrc_t;
  typedef enum logic [1:0] {
    ST_RUN  = 2'h0,
    ST_STOP = 2'h1,
    ST_WARM = 2'h3
  } mode_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apbReq_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apbRsp_t;
  typedef struct packed {
    mode_t       mode;
    clkSrc_t     src;
    logic [1:0]  cdiv;
    logic        power_manage_enable;
    logic        loop_mode_select;
    logic        swben;
    logic        svEn;
    logic        svIe;
    logic        svStop;
    logic        svActive;
    logic [3:0]  supply_threshold_field;
    logic [16:0] warmCnt;
    logic [15:0] settleCnt;
    logic        svRdy;
    logic [2:0]  stat;
    logic [2:0]  mask;
    logic [7:0]  divCnt;
    logic        sysTick;
    logic        useFll;
    logic        lowSync1;
    logic        lowSync2;
    logic        irqSync1;
    logic        irqSync2;
    logic        oscSync1;
    logic        oscSync2;
    logic        oscPrev;
    logic [31:0] rdata;
  } state_t;
endpackage

// >>> sim/sysclk_checker.sv
`timescale 1ns/10ps
module sysclk_checker
  import sysclk_pkg::*;
#(parameter int WARMUP_COUNT = 65536) (
  // Clock and reset
  input wire logic                mclk,
  input wire logic                reset,
  // Bus and pins
  input wire sysclk_pkg::apbReq_t apbReq,
  input wire sysclk_pkg::apbRsp_t apbRsp,
  input wire logic                oscIn,
  input wire logic                supplyLow,
  input wire logic                extIrq,
  input wire logic                serialActive,
  // Outputs
  input wire logic                sysClkTick,
  input wire logic                oscEnable,
  input wire logic                fllLocked,
  input wire logic [1:0]          activeSrc,
  input wire logic [3:0]          supplyThreshold,
  input wire logic                monitorPowered,
  input wire logic                irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic       wrAcc;
  logic       rdAcc;
  logic       stopWr;
  logic [3:0] thNew;
  assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign rdAcc = apbReq.psel && apbReq.penable && !apbReq.pwrite;
  assign stopWr = wrAcc && apbReq.paddr == 12'h010 && apbReq.pwdata[0];
  assign thNew = apbReq.pwdata[7:4];
  property p_wrReady; wrAcc |-> apbRsp.pready && !apbRsp.pslverr; endproperty
  a_wrReady: assert property (p_wrReady)
    else $error("write not answered in first access cycle");
  property p_rdWait; $rose(rdAcc) |-> !apbRsp.pready ##1 apbRsp.pready;
  endproperty
  a_rdWait: assert property (p_rdWait) else $error("read wait state wrong");
  property p_reset;
    $fell(reset) |-> supplyThreshold == 4'h7 && activeSrc == 2'h2 && oscEnable;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset values wrong");
  property p_th;
    wrAcc && apbReq.paddr == 12'h004 |=> supplyThreshold == $past(thNew);
  endproperty
  a_th: assert property (p_th) else $error("threshold not applied");
  property p_lock; fllLocked |-> activeSrc == 2'h2; endproperty
  a_lock: assert property (p_lock) else $error("lock without loop");
  property p_halt; !oscEnable ##1 !oscEnable |-> !sysClkTick; endproperty
  a_halt: assert property (p_halt) else $error("tick in stop");
  property p_stopCause; $fell(oscEnable) |-> $past(stopWr); endproperty
  a_stopCause: assert property (p_stopCause)
    else $error("oscillator stopped without command");
  property p_wake; !oscEnable && extIrq |-> ##[1:6] oscEnable; endproperty
  a_wake: assert property (p_wake) else $error("no wake from stop");
  property p_warm; $rose(oscEnable) |-> (activeSrc != 2'h1) [*8]; endproperty
  a_warm: assert property (p_warm) else $error("crystal used unwarmed");
  c_stop: cover property (stopWr);
  c_irq: cover property ($rose(irq));
  c_wake: cover property ($rose(oscEnable));
endmodule
bind sysclk_ctrl sysclk_checker #(.WARMUP_COUNT(WARMUP_COUNT)) u_sysclk_checker
  (.mclk, .reset, .apbReq, .apbRsp, .oscIn, .supplyLow, .extIrq,
   .serialActive, .sysClkTick, .oscEnable, .fllLocked, .activeSrc,
   .supplyThreshold, .monitorPowered, .irq);

// >>> sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import sysclk_pkg::*;
  logic mclk, reset, oscIn, supplyLow, extIrq, serialActive;
  logic sysClkTick, oscEnable, fllLocked, irq, monitorPowered;
  logic [1:0] activeSrc;
  logic [3:0] supplyThreshold;
  apbReq_t q;
  apbRsp_t rsp;
  logic [31:0] r;
  int n_mismatch, n_checks;
  sysclk_ctrl #(.WARMUP_COUNT(8)) u_sysclk_ctrl (.mclk, .reset, .apbReq(q),
    .apbRsp(rsp), .oscIn, .supplyLow, .extIrq, .serialActive, .sysClkTick,
    .oscEnable, .fllLocked, .activeSrc, .supplyThreshold, .monitorPowered,
    .irq);
  xtal_model u_xtal_model (.enable(oscEnable), .osc(oscIn));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bail;
    n_mismatch++;
    $display("mismatch wait expected done seen timeout");
    report_and_stop;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    q <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    q.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) bail;
    r = rsp.prdata;
    q.psel <= 1'b0;
    q.penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read", r, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic gap(output int c);
    int n;
    n = 0;
    do begin @(negedge mclk); n++; end while (sysClkTick !== 1'b1 && n < 600);
    c = 0;
    do begin @(negedge mclk); c++; end while (sysClkTick !== 1'b1 && c < 600);
  endtask
  task automatic waitFor(input logic osc, output int n);
    n = 0;
    while ((osc ? oscEnable !== 1'b1 : activeSrc !== 2'h1) && n < 900) begin
      @(negedge mclk);
      n++;
    end
    if (n == 900) bail;
  endtask
  task automatic t_reset;
    rd(12'h000, 32'h28);
    rd(12'h004, 32'h70);
    rd(12'h020, 32'h0);
    chk("src", 32'(activeSrc), 32'h2);
    chk("lock", 32'(fllLocked), 32'h1);
    apb(1'b1, 12'h000, 32'h20);
    cyc(3);
    chk("src", 32'(activeSrc), 32'h3);
    chk("lock", 32'(fllLocked), 32'h0);
  endtask
  task automatic t_divide;
    int c;
    int div[5] = '{1, 2, 4, 8, 256};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 12'h000, i < 4 ? 32'h28 | 32'(i) : 32'h2C);
      gap(c);
      gap(c);
      chk("divisor", 32'(c), 32'(div[i]));
    end
  endtask
  task automatic t_switch;
    apb(1'b1, 12'h000, 32'h6C);
    serialActive <= 1'b1;
    @(posedge mclk) serialActive <= 1'b0;
    rd(12'h000, 32'h68);
    apb(1'b1, 12'h000, 32'h6C);
    extIrq <= 1'b1;
    cyc(4);
    @(posedge mclk) extIrq <= 1'b0;
    rd(12'h000, 32'h68);
    apb(1'b0, 12'h008, 32'h0);
    chk("swStat", r & 32'h2, 32'h2);
  endtask
  task automatic t_monitor;
    apb(1'b1, 12'h004, 32'h83);
    cyc(110);
    rd(12'h004, 32'h8B);
    chk("th", 32'(supplyThreshold), 32'h8);
    apb(1'b1, 12'h00C, 32'h0);
    supplyLow <= 1'b1;
    cyc(8);
    chk("masked", 32'(irq), 32'h0);
    apb(1'b1, 12'h00C, 32'h7);
    cyc(2);
    chk("irq", 32'(irq), 32'h1);
    @(posedge mclk) supplyLow <= 1'b0;
    cyc(4);
    apb(1'b0, 12'h008, 32'h0);
    chk("lowStat", r & 32'h1, 32'h1);
    cyc(2);
    chk("irq", 32'(irq), 32'h0);
  endtask
  task automatic t_stop;
    int n, k;
    apb(1'b1, 12'h000, 32'h10);
    waitFor(1'b0, n);
    apb(1'b1, 12'h010, 32'h1);
    cyc(3);
    chk("osc", 32'(oscEnable), 32'h0);
    chk("pwr", 32'(monitorPowered), 32'h0);
    k = 0;
    repeat (20) begin @(negedge mclk); k += int'(sysClkTick === 1'b1); end
    chk("ticks", 32'(k), 32'h0);
    @(posedge mclk) extIrq <= 1'b1;
    waitFor(1'b1, n);
    @(posedge mclk) extIrq <= 1'b0;
    chk("warmSrc", 32'(activeSrc !== 2'h1), 32'h1);
    waitFor(1'b0, n);
    chk("warmLen", 32'(n >= 8), 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk("warmDone", r & 32'h4, 32'h4);
    apb(1'b1, 12'h004, 32'h87);
    apb(1'b1, 12'h010, 32'h1);
    cyc(3);
    chk("pwr", 32'(monitorPowered), 32'h1);
    @(posedge mclk) supplyLow <= 1'b1;
    waitFor(1'b1, n);
    chk("wake", 32'(oscEnable), 32'h1);
    @(posedge mclk) supplyLow <= 1'b0;
  endtask
  initial begin
    q = '0;
    reset = 1'b1;
    supplyLow = 1'b0;
    extIrq = 1'b0;
    serialActive = 1'b0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    t_reset;
    t_divide;
    t_switch;
    t_monitor;
    t_stop;
    report_and_stop;
  end
endmodule

// >>> sim/xtal_model.sv
`timescale 1ns/10ps
module xtal_model #(parameter int HALF_NS = 23) (
  // Oscillator
  input  wire logic enable,
  output logic      osc
);
  // A stopped crystal does not swing, so the pin rests low.
  initial osc = 1'b0;
  always begin
    #(HALF_NS);
    osc = enable ? ~osc : 1'b0;
  end
endmodule
